// ==== inc/rizfc_pkg.sv ====
package rizfc_pkg;
  // Envelope bytes; only the delimiter and checksum base serve both directions
  localparam logic [7:0]  START_DELIM  = 8'h7E;
  localparam logic [7:0]  CSUM_BASE    = 8'hFF;
  localparam logic [7:0]  FT_ROUTE_IND = 8'hA3;
  localparam logic [7:0]  FT_EXPL_TX   = 8'h11;
  localparam logic [7:0]  IND_LEN_HI   = 8'h00;
  localparam logic [7:0]  IND_LEN_LO   = 8'h0C;
  localparam logic [7:0]  RSVD_BYTE    = 8'h00;
  // Indicator frame byte positions
  localparam logic [3:0]  IX_DELIM     = 4'h0;
  localparam logic [3:0]  IX_LEN_HI    = 4'h1;
  localparam logic [3:0]  IX_LEN_LO    = 4'h2;
  localparam logic [3:0]  IX_TYPE      = 4'h3;
  localparam logic [3:0]  IX_SRC64_LST = 4'hB;
  localparam logic [3:0]  IX_SRC16_HI  = 4'hC;
  localparam logic [3:0]  IX_SRC16_LO  = 4'hD;
  localparam logic [3:0]  IX_RSVD      = 4'hE;
  localparam logic [3:0]  IX_CSUM      = 4'hF;
  // Explicit transmit frame offsets
  localparam logic [15:0] OFS_TYPE     = 16'h0003;
  localparam logic [15:0] OFS_FRAME_ID = 16'h0004;
  localparam logic [15:0] OFS_DST64_F  = 16'h0005;
  localparam logic [15:0] OFS_DST64_L  = 16'h000C;
  localparam logic [15:0] OFS_DST16_HI = 16'h000D;
  localparam logic [15:0] OFS_DST16_LO = 16'h000E;
  localparam logic [15:0] OFS_SRC_EP   = 16'h000F;
  localparam logic [15:0] OFS_DST_EP   = 16'h0010;
  localparam logic [15:0] OFS_CLUS_HI  = 16'h0011;
  localparam logic [15:0] OFS_CLUS_LO  = 16'h0012;
  localparam logic [15:0] OFS_PROF_HI  = 16'h0013;
  localparam logic [15:0] OFS_PROF_LO  = 16'h0014;
  localparam logic [15:0] OFS_RADIUS   = 16'h0015;
  localparam logic [15:0] OFS_OPTIONS  = 16'h0016;
  localparam logic [15:0] OFS_PAY_LO   = 16'h0017;
  localparam logic [15:0] OFS_PAY_HI   = 16'h0018;
  localparam logic [15:0] OFS_LEN_SKEW = 16'h0002;
  localparam logic [15:0] EXPL_HDR_LEN = 16'h0014;
  // Addressing and device-object values
  localparam logic [63:0] COORD64      = 64'h0000_0000_0000_0000;
  localparam logic [63:0] BCAST64      = 64'h0000_0000_0000_FFFF;
  localparam logic [15:0] NWK_UNKNOWN  = 16'hFFFE;
  localparam logic [7:0]  ZDO_EP       = 8'h00;
  localparam logic [15:0] ZDO_PROFILE  = 16'h0000;
  localparam logic [7:0]  ZDO_OPTIONS  = 8'h00;
  localparam logic [7:0]  NO_STATUS_ID = 8'h00;
  localparam logic [7:0]  RADIUS_AUTO  = 8'h00;

  typedef enum logic [2:0] {
    RX_IDLE, RX_LEN_HI, RX_LEN_LO, RX_DATA, RX_CSUM
  } rizfc_rx_st_t;

  // Cluster identifiers the block recognises
  function automatic logic rizfc_cluster_known(input logic [15:0] c);
    case (c)
      16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0005, 16'h0006,
      16'h0031, 16'h0032, 16'h0034, 16'h0036, 16'h0038: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Running sum of frame data; checksum is base minus this sum
  function automatic logic [7:0] rizfc_sum(input logic [7:0] a,
                                           input logic [7:0] b);
    return 8'(a + b);
  endfunction
endpackage

// ==== inc/rizfc_ind_if.sv ====
`timescale 1ns/1ps
interface rizfc_ind_if;
  logic        start;
  logic [63:0] src64;
  logic [15:0] src16;
  logic        busy;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        tx_ready;
  modport ctl    (output start, src64, src16, tx_ready,
                  input  busy, tx_valid, tx_data);
  modport framer (input  start, src64, src16, tx_ready,
                  output busy, tx_valid, tx_data);
endinterface

// ==== rtl/rizfc_ind_tx.sv ====
`timescale 1ns/1ps
module rizfc_ind_tx (
  input wire logic mclk,
  input wire logic rstn,
  rizfc_ind_if.framer ind
);
  logic [3:0]  idx_r;
  logic [7:0]  sum_r;
  logic [63:0] src64_r;
  logic [15:0] src16_r;
  logic        busy_r;
  logic        tx_valid_r;
  logic [7:0]  tx_data_r;
  logic        hs;
  logic        load;
  logic [3:0]  idx_nxt;
  logic [7:0]  sum_nxt;
  logic [7:0]  tx_data_nxt;

  function automatic logic [7:0] byte_at(input logic [3:0] i,
                                         input logic [63:0] a64,
                                         input logic [15:0] a16,
                                         input logic [7:0]  s);
    case (i)
      rizfc_pkg::IX_DELIM:    return rizfc_pkg::START_DELIM;
      rizfc_pkg::IX_LEN_HI:   return rizfc_pkg::IND_LEN_HI;
      rizfc_pkg::IX_LEN_LO:   return rizfc_pkg::IND_LEN_LO;
      rizfc_pkg::IX_TYPE:     return rizfc_pkg::FT_ROUTE_IND;
      rizfc_pkg::IX_SRC16_HI: return a16[15:8];
      rizfc_pkg::IX_SRC16_LO: return a16[7:0];
      rizfc_pkg::IX_RSVD:     return rizfc_pkg::RSVD_BYTE;
      rizfc_pkg::IX_CSUM:     return 8'(rizfc_pkg::CSUM_BASE - s);
      // Offsets 4..11: long address, most significant byte first
      default: return a64[8*(rizfc_pkg::IX_SRC64_LST - i) +: 8];
    endcase
  endfunction

  assign hs      = tx_valid_r & ind.tx_ready;
  assign load    = ind.start & ~busy_r;
  assign idx_nxt = 4'(idx_r + 4'h1);
  // Delimiter and length stay out of the checksum
  assign sum_nxt = (idx_r >= rizfc_pkg::IX_TYPE) ?
                   rizfc_pkg::rizfc_sum(sum_r, tx_data_r) : sum_r;
  assign tx_data_nxt = byte_at(idx_nxt, src64_r, src16_r, sum_nxt);

  // Bytes go out back to back while the sink keeps ready high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      idx_r      <= 4'h0;
      sum_r      <= 8'h00;
      src64_r    <= 64'h0000_0000_0000_0000;
      src16_r    <= 16'h0000;
      busy_r     <= 1'b0;
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
    end else if (load) begin
      idx_r      <= rizfc_pkg::IX_DELIM;
      sum_r      <= 8'h00;
      src64_r    <= ind.src64;
      src16_r    <= ind.src16;
      busy_r     <= 1'b1;
      tx_valid_r <= 1'b1;
      tx_data_r  <= rizfc_pkg::START_DELIM;
    end else if (hs) begin
      idx_r      <= idx_nxt;
      sum_r      <= sum_nxt;
      busy_r     <= (idx_r != rizfc_pkg::IX_CSUM);
      tx_valid_r <= (idx_r != rizfc_pkg::IX_CSUM);
      tx_data_r  <= tx_data_nxt;
    end
  end

  assign ind.busy     = busy_r;
  assign ind.tx_valid = tx_valid_r;
  assign ind.tx_data  = tx_data_r;
endmodule

// ==== rtl/rizfc_top.sv ====
`timescale 1ns/1ps
module rizfc_top (
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Route request event from the network stack
  input  wire logic        route_req,
  input  wire logic [63:0] route_req_src64,
  input  wire logic [15:0] route_req_src16,
  input  wire logic [7:0]  net_max_hops,
  // Byte stream toward the host
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  // Byte stream from the host
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // Decoded explicit transmit command
  output logic             cmd_valid,
  output logic [7:0]       cmd_frame_id,
  output logic             cmd_status_req,
  output logic [63:0]      cmd_dst64,
  output logic             cmd_to_coord,
  output logic             cmd_bcast,
  output logic [15:0]      cmd_dst16,
  output logic             cmd_nwk_unknown,
  output logic [15:0]      cmd_cluster,
  output logic             cmd_cluster_known,
  output logic             cmd_zdo_ok,
  output logic [7:0]       cmd_radius,
  output logic [15:0]      target_network_address,
  output logic [15:0]      cmd_payload_len,
  output logic             frame_err,
  output logic             ind_pending,
  output logic             ind_overrun
);
  rizfc_ind_if ind ();

  rizfc_ind_tx u_ind_tx (
    .mclk (mclk),
    .rstn (rstn),
    .ind  (ind.framer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Indicator request hold
  logic        pend_r;
  logic [63:0] pend64_r;
  logic [15:0] pend16_r;
  logic        ovr_r;
  logic        issue;

  assign issue        = pend_r & ~ind.busy;
  assign ind.start    = issue;
  assign ind.src64    = pend64_r;
  assign ind.src16    = pend16_r;
  assign ind.tx_ready = tx_ready;
  assign tx_valid     = ind.tx_valid;
  assign tx_data      = ind.tx_data;

  // One request held while a frame is on the wire; a newer one replaces it
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pend_r   <= 1'b0;
      pend64_r <= 64'h0000_0000_0000_0000;
      pend16_r <= 16'h0000;
      ovr_r    <= 1'b0;
    end else begin
      pend_r <= route_req | (pend_r & ~issue);
      ovr_r  <= route_req & pend_r & ~issue;
      if (route_req) begin
        pend64_r <= route_req_src64;
        pend16_r <= route_req_src16;
      end
    end
  end

  assign ind_pending = pend_r;
  assign ind_overrun = ovr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Host frame parser
  rizfc_pkg::rizfc_rx_st_t st_r;
  rizfc_pkg::rizfc_rx_st_t st_nxt;
  logic [15:0] len_r;
  logic [15:0] ofs_r;
  logic [7:0]  sum_r;
  logic [7:0]  type_r;
  logic [7:0]  fid_r;
  logic [63:0] d64_r;
  logic [15:0] d16_r;
  logic [7:0]  sep_r;
  logic [7:0]  dep_r;
  logic [15:0] clus_r;
  logic [15:0] prof_r;
  logic [7:0]  rad_r;
  logic [7:0]  opt_r;
  logic [15:0] tgt_r;
  logic        in_d64;
  logic        last_data;
  logic        csum_ok;
  logic        frame_end;
  logic        take;
  logic [15:0] len_nxt;
  logic [7:0]  sum_nxt;

  assign len_nxt   = {len_r[7:0], rx_data};
  assign last_data = (ofs_r == 16'(len_r + rizfc_pkg::OFS_LEN_SKEW));
  assign sum_nxt   = rizfc_pkg::rizfc_sum(sum_r, rx_data);
  assign csum_ok   = (sum_nxt == rizfc_pkg::CSUM_BASE);
  assign frame_end = rx_valid & (st_r == rizfc_pkg::RX_CSUM);
  // Short frames or other types are not commands for this block
  assign take      = frame_end & csum_ok &
                     (type_r == rizfc_pkg::FT_EXPL_TX) &
                     (len_r >= rizfc_pkg::EXPL_HDR_LEN);
  assign in_d64    = (ofs_r >= rizfc_pkg::OFS_DST64_F) &
                     (ofs_r <= rizfc_pkg::OFS_DST64_L);

  always_comb begin
    st_nxt = st_r;
    if (rx_valid) begin
      case (st_r)
        rizfc_pkg::RX_IDLE:
          if (rx_data == rizfc_pkg::START_DELIM) begin
            st_nxt = rizfc_pkg::RX_LEN_HI;
          end
        rizfc_pkg::RX_LEN_HI: st_nxt = rizfc_pkg::RX_LEN_LO;
        rizfc_pkg::RX_LEN_LO:
          st_nxt = (len_nxt == 16'h0000) ? rizfc_pkg::RX_CSUM :
                                           rizfc_pkg::RX_DATA;
        rizfc_pkg::RX_DATA:
          if (last_data) begin
            st_nxt = rizfc_pkg::RX_CSUM;
          end
        rizfc_pkg::RX_CSUM: st_nxt = rizfc_pkg::RX_IDLE;
        default: st_nxt = rizfc_pkg::RX_IDLE;
      endcase
    end
  end

  // A byte may arrive on every clock; nothing waits between bytes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_r  <= rizfc_pkg::RX_IDLE;
      len_r <= 16'h0000;
      ofs_r <= 16'h0000;
      sum_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      if (rx_valid && st_r == rizfc_pkg::RX_LEN_HI) begin
        len_r <= {8'h00, rx_data};
      end else if (rx_valid && st_r == rizfc_pkg::RX_LEN_LO) begin
        len_r <= len_nxt;
        ofs_r <= rizfc_pkg::OFS_TYPE;
        sum_r <= 8'h00;
      end else if (rx_valid && st_r == rizfc_pkg::RX_DATA) begin
        ofs_r <= 16'(ofs_r + 16'h0001);
        sum_r <= sum_nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field capture by offset; header fields are big-endian on the wire
  logic cap;
  assign cap = rx_valid & (st_r == rizfc_pkg::RX_DATA);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      type_r <= 8'h00;
      fid_r  <= 8'h00;
      d64_r  <= 64'h0000_0000_0000_0000;
      d16_r  <= 16'h0000;
      sep_r  <= 8'h00;
      dep_r  <= 8'h00;
    end else if (cap) begin
      if (ofs_r == rizfc_pkg::OFS_TYPE)     type_r <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_FRAME_ID) fid_r  <= rx_data;
      if (in_d64) d64_r <= {d64_r[55:0], rx_data};
      if (ofs_r == rizfc_pkg::OFS_DST16_HI) d16_r[15:8] <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_DST16_LO) d16_r[7:0]  <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_SRC_EP)   sep_r  <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_DST_EP)   dep_r  <= rx_data;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clus_r <= 16'h0000;
      prof_r <= 16'h0000;
      rad_r  <= 8'h00;
      opt_r  <= 8'h00;
      tgt_r  <= 16'h0000;
    end else if (cap) begin
      if (ofs_r == rizfc_pkg::OFS_CLUS_HI) clus_r[15:8] <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_CLUS_LO) clus_r[7:0]  <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_PROF_HI) prof_r[15:8] <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_PROF_LO) prof_r[7:0]  <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_RADIUS)  rad_r  <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_OPTIONS) opt_r  <= rx_data;
      // Payload parameters are little-endian: low byte first
      if (ofs_r == rizfc_pkg::OFS_PAY_LO) tgt_r[7:0]  <= rx_data;
      if (ofs_r == rizfc_pkg::OFS_PAY_HI) tgt_r[15:8] <= rx_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command result registers, loaded when a good frame closes
  logic        cv_r;
  logic        ferr_r;
  logic [7:0]  ofid_r;
  logic        osts_r;
  logic [63:0] od64_r;
  logic        ocrd_r;
  logic        obc_r;
  logic [15:0] od16_r;
  logic        ounk_r;
  logic [15:0] oclu_r;
  logic        oknw_r;
  logic        ozdo_r;
  logic [7:0]  orad_r;
  logic [15:0] otgt_r;
  logic [15:0] oplen_r;
  logic        zdo_ok_w;
  logic [7:0]  rad_eff;

  // Zero radius is replaced by net_max_hops, so downstream sees an unlimited hop count only if net_max_hops is zero
  assign rad_eff  = (rad_r == rizfc_pkg::RADIUS_AUTO) ? net_max_hops :
                                                        rad_r;
  assign zdo_ok_w = (sep_r == rizfc_pkg::ZDO_EP) &
                    (dep_r == rizfc_pkg::ZDO_EP) &
                    (prof_r == rizfc_pkg::ZDO_PROFILE) &
                    (opt_r == rizfc_pkg::ZDO_OPTIONS);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cv_r   <= 1'b0;
      ferr_r <= 1'b0;
    end else begin
      cv_r   <= take;
      ferr_r <= frame_end & ~csum_ok;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ofid_r  <= 8'h00;
      osts_r  <= 1'b0;
      od64_r  <= 64'h0000_0000_0000_0000;
      ocrd_r  <= 1'b0;
      obc_r   <= 1'b0;
      od16_r  <= 16'h0000;
      ounk_r  <= 1'b0;
      oclu_r  <= 16'h0000;
      oknw_r  <= 1'b0;
      ozdo_r  <= 1'b0;
      orad_r  <= 8'h00;
      otgt_r  <= 16'h0000;
      oplen_r <= 16'h0000;
    end else if (take) begin
      ofid_r  <= fid_r;
      osts_r  <= (fid_r != rizfc_pkg::NO_STATUS_ID);
      od64_r  <= d64_r;
      ocrd_r  <= (d64_r == rizfc_pkg::COORD64);
      obc_r   <= (d64_r == rizfc_pkg::BCAST64);
      od16_r  <= d16_r;
      ounk_r  <= (d16_r == rizfc_pkg::NWK_UNKNOWN);
      oclu_r  <= clus_r;
      oknw_r  <= rizfc_pkg::rizfc_cluster_known(clus_r);
      ozdo_r  <= zdo_ok_w;
      orad_r  <= rad_eff;
      otgt_r  <= tgt_r;
      oplen_r <= 16'(len_r - rizfc_pkg::EXPL_HDR_LEN);
    end
  end

  assign cmd_valid              = cv_r;
  assign frame_err              = ferr_r;
  assign cmd_frame_id           = ofid_r;
  assign cmd_status_req         = osts_r;
  assign cmd_dst64              = od64_r;
  assign cmd_to_coord           = ocrd_r;
  assign cmd_bcast              = obc_r;
  assign cmd_dst16              = od16_r;
  assign cmd_nwk_unknown        = ounk_r;
  assign cmd_cluster            = oclu_r;
  assign cmd_cluster_known      = oknw_r;
  assign cmd_zdo_ok             = ozdo_r;
  assign cmd_radius             = orad_r;
  assign target_network_address = otgt_r;
  assign cmd_payload_len        = oplen_r;
endmodule

// ==== dv/rizfc_chk.sv ====
`timescale 1ns/1ps
module rizfc_chk (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        route_req,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_frame_id,
  input wire logic        cmd_status_req,
  input wire logic [63:0] cmd_dst64,
  input wire logic        cmd_to_coord,
  input wire logic        cmd_bcast,
  input wire logic [15:0] cmd_dst16,
  input wire logic        cmd_nwk_unknown,
  input wire logic        frame_err,
  input wire logic        ind_pending
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////
  // Frames are always 16 bytes, so a wrapping count tracks the position
  logic [3:0]      pos_r;
  logic [7:0]      sum_r;
  wire logic       acc     = tx_valid && tx_ready;
  wire logic [3:0] pos_nxt = pos_r + 4'h1;
  wire logic [7:0] sum_nxt = (pos_r == 4'hF) ? 8'h00 :
                             (pos_r >= 4'h3) ? 8'(sum_r + tx_data) : sum_r;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_r <= 4'h0;
      sum_r <= 8'h00;
    end else if (acc) begin
      pos_r <= pos_nxt;
      sum_r <= sum_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Request from idle: nothing on the wire now or in the last two cycles
  sequence s_idle_req;
    route_req && !ind_pending && !tx_valid && !$past(tx_valid) &&
    !$past(tx_valid, 2);
  endsequence
  sequence s_frame_open;
    ##1 ind_pending ##1 (tx_valid && tx_data == rizfc_pkg::START_DELIM);
  endsequence
  a_ind_launch: assert property (s_idle_req |-> s_frame_open)
    else $error("indicator frame did not open two cycles after request");
  a_req_pend: assert property (route_req |=> ind_pending)
    else $error("route request not held pending");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("tx byte changed while stalled");
  a_ind_delim: assert property (
    tx_valid && pos_r == rizfc_pkg::IX_DELIM
    |-> tx_data == rizfc_pkg::START_DELIM)
    else $error("indicator frame does not start with delimiter");
  a_ind_len: assert property (
    tx_valid && pos_r == rizfc_pkg::IX_LEN_LO
    |-> tx_data == 8'h0C)
    else $error("indicator length byte wrong");
  a_ind_type: assert property (
    tx_valid && pos_r == rizfc_pkg::IX_TYPE
    |-> tx_data == 8'hA3)
    else $error("indicator frame type wrong");
  a_ind_rsvd: assert property (
    tx_valid && pos_r == rizfc_pkg::IX_RSVD
    |-> tx_data == 8'h00)
    else $error("indicator reserved byte not zero");
  a_ind_csum: assert property (
    tx_valid && pos_r == rizfc_pkg::IX_CSUM
    |-> tx_data == 8'(8'hFF - sum_r))
    else $error("indicator checksum wrong");
  a_cmd_flags: assert property (cmd_valid |->
    cmd_status_req == (cmd_frame_id != 8'h00) &&
    cmd_to_coord == (cmd_dst64 == 64'h0000_0000_0000_0000) &&
    cmd_bcast == (cmd_dst64 == 64'h0000_0000_0000_FFFF) &&
    cmd_nwk_unknown == (cmd_dst16 == 16'hFFFE))
    else $error("command flags disagree with fields");
  a_cmd_pulse: assert property ((cmd_valid || frame_err) |=>
    !(cmd_valid || frame_err))
    else $error("frame result longer than one cycle");
endmodule

bind rizfc_top rizfc_chk u_chk (
  .mclk(mclk), .rstn(rstn), .route_req(route_req), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .cmd_valid(cmd_valid),
  .cmd_frame_id(cmd_frame_id), .cmd_status_req(cmd_status_req),
  .cmd_dst64(cmd_dst64), .cmd_to_coord(cmd_to_coord),
  .cmd_bcast(cmd_bcast), .cmd_dst16(cmd_dst16),
  .cmd_nwk_unknown(cmd_nwk_unknown), .frame_err(frame_err),
  .ind_pending(ind_pending)
);

// ==== dv/rizfc_host.sv ====
`timescale 1ns/1ps
module rizfc_host (
  input  wire logic       mclk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  // Host runs with explicit receive frames selected
  localparam int api_output_select = 1;
  logic [7:0] got[$];
  logic       stall = 1'b0;
  logic [2:0] k_r   = 3'h0;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // A byte is taken only where valid and ready meet
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
  // Slow host drops ready on a fixed pattern
  always @(negedge mclk) begin
    k_r      <= k_r + 3'h1;
    tx_ready <= !stall || (k_r[0] ^ k_r[2]);
  end
  // Idle data line toggles so a stale byte is never mistaken for a new one
  task automatic send(input logic [7:0] f[$], input int gap);
    foreach (f[i]) begin
      repeat (gap) begin
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data;
      end
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_data  = f[i];
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        mclk, rstn, route_req, kn;
  logic [63:0] src64, a, d64;
  logic [15:0] src16, s, d16, cl, tna;
  logic [7:0]  hops, fid, ep, rad;
  wire logic   tx_valid, tx_ready, rx_valid, c_vld, f_err, pend, ovr;
  wire logic   c_sr, c_co, c_bc, c_nu, c_ck, c_zok;
  wire logic [7:0]  tx_data, rx_data, c_id, c_rad;
  wire logic [63:0] c64;
  wire logic [15:0] c16, c_cl, c_tna, c_len;
  logic [7:0]  exp_q[$];
  logic [31:0] rng = 32'h0000_DC25;
  logic [15:0] cls[12] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
    16'h0005, 16'h0006, 16'h0031, 16'h0032, 16'h0034, 16'h0036,
    16'h0038, 16'h0003};
  int errors = 0;
  int check_count = 0;

  rizfc_top dut (.mclk(mclk), .rstn(rstn), .route_req(route_req),
    .route_req_src64(src64), .route_req_src16(src16),
    .net_max_hops(hops), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .cmd_valid(c_vld), .cmd_frame_id(c_id), .cmd_status_req(c_sr),
    .cmd_dst64(c64), .cmd_to_coord(c_co), .cmd_bcast(c_bc),
    .cmd_dst16(c16), .cmd_nwk_unknown(c_nu), .cmd_cluster(c_cl),
    .cmd_cluster_known(c_ck), .cmd_zdo_ok(c_zok), .cmd_radius(c_rad),
    .target_network_address(c_tna), .cmd_payload_len(c_len),
    .frame_err(f_err), .ind_pending(pend), .ind_overrun(ovr));
  rizfc_host host (.mclk(mclk), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(input string n, input logic [63:0] e,
                     input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic ind_model(input logic [63:0] x, input logic [15:0] y);
    logic [7:0] f[$];
    logic [7:0] sm;
    f = {8'h7E, 8'h00, 8'h0C, 8'hA3};
    for (int i = 7; i >= 0; i--) f.push_back(x[i*8 +: 8]);
    f = {f, y[15:8], y[7:0], 8'h00};
    sm = 8'h00;
    for (int i = 3; i < 15; i++) sm += f[i];
    f.push_back(8'(8'hFF - sm));
    exp_q = {exp_q, f};
  endtask
  task automatic req(input logic [63:0] x, input logic [15:0] y);
    @(negedge mclk);
    route_req = 1'b1;
    src64     = x;
    src16     = y;
    @(negedge mclk);
    route_req = 1'b0;
    src64     = ~x;
    src16     = ~y;
  endtask
  task automatic wait_bytes(input int n);
    int t;
    for (t = 0; t < 3000 && host.got.size() < n; t++) @(negedge mclk);
    if (t == 3000) begin
      errors++;
      $display("unexpected byte count expected %0d seen %0d", n,
               host.got.size());
      end_of_test();
    end
  endtask
  // Builds a frame from the current field values and checks the decode
  task automatic cmd(input logic [7:0] ty, input logic bad);
    logic [7:0] f[$];
    logic [7:0] sm;
    f = {8'h7E, 8'h00, 8'h16, ty, fid};
    for (int i = 7; i >= 0; i--) f.push_back(d64[i*8 +: 8]);
    f = {f, d16[15:8], d16[7:0], ep, 8'h00, cl[15:8], cl[7:0]};
    f = {f, 8'h00, 8'h00, rad, 8'h00, tna[7:0], tna[15:8]};
    sm = 8'h00;
    for (int i = 3; i < f.size(); i++) sm += f[i];
    f.push_back(8'(8'hFF - sm) ^ {7'h00, bad});
    host.send(f, int'(xs() % 3));
    chk("frame_err", 64'(bad), 64'(f_err));
    chk("cmd_valid", 64'(ty == 8'h11 && !bad), 64'(c_vld));
    if (ty == 8'h11 && !bad) begin
      chk("frame id", 64'(fid), 64'(c_id));
      chk("status req", 64'(fid != 8'h00), 64'(c_sr));
      chk("dst64", d64, c64);
      chk("coord", 64'(d64 == 64'h0), 64'(c_co));
      chk("bcast", 64'(d64 == 64'h0000_0000_0000_FFFF), 64'(c_bc));
      chk("dst16", 64'(d16), 64'(c16));
      chk("unknown", 64'(d16 == 16'hFFFE), 64'(c_nu));
      chk("cluster", 64'(cl), 64'(c_cl));
      chk("known", 64'(kn), 64'(c_ck));
      chk("zdo ok", 64'(ep == 8'h00), 64'(c_zok));
      chk("radius", 64'((rad == 8'h00) ? hops : rad), 64'(c_rad));
      chk("target", 64'(tna), 64'(c_tna));
      chk("pay len", 64'h0000_0000_0000_0002, 64'(c_len));
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    rstn      = 1'b0;
    route_req = 1'b0;
    src64     = 64'h0;
    src16     = 16'h0;
    hops      = 8'h1E;
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    // Three requests: the second waits and is replaced by the third
    host.stall = 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = {xs(), xs()};
      s = 16'(xs());
      req(a, s);
      chk("pending", 64'h1, 64'(pend));
      if (i != 1) ind_model(a, s);
      if (i == 0) wait_bytes(1);
      if (i == 2) chk("overrun", 64'h1, 64'(ovr));
    end
    wait_bytes(32);
    chk("tx count", 64'(exp_q.size()), 64'(host.got.size()));
    foreach (exp_q[i]) begin
      chk("tx byte", 64'(exp_q[i]), 64'(host.got[i]));
    end
    $display("test indicator done");
    host.stall = 1'b0;
    foreach (cls[i]) begin
      fid  = (i == 0) ? 8'h00 : 8'(xs());
      d64  = (i == 1) ? 64'h0 : {xs(), xs()};
      if (i == 2) d64 = 64'h0000_0000_0000_FFFF;
      d16  = (i == 2) ? 16'hFFFE : 16'(xs());
      cl   = cls[i];
      kn   = (i < 11);
      tna  = 16'(xs());
      ep   = (i == 3) ? 8'h01 : 8'h00;
      rad  = (i == 4) ? 8'h00 : 8'(xs());
      hops = 8'(xs());
      cmd(8'h11, 1'b0);
    end
    cmd(8'h11, 1'b1);
    cmd(8'h10, 1'b0);
    // Noise, an empty frame, then a command frame too short for a header
    exp_q = {8'h55, 8'h7E, 8'h00, 8'h00, 8'hFF,
             8'h7E, 8'h00, 8'h02, 8'h11, 8'h5A, 8'h94};
    host.send(exp_q, 0);
    chk("short cmd_valid", 64'h0, 64'(c_vld));
    chk("short frame_err", 64'h0, 64'(f_err));
    $display("test command done");
    end_of_test();
  end
endmodule
